// ---- hdl/acc_conv_ctrl.sv ----
`default_nettype none
module acc_conv_ctrl (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic        cs_n,
    input  wire logic        start_pin,
    input  wire logic [7:0]  mode_config_0,
    input  wire logic [7:0]  mode_config_1,
    input  wire logic        sinc2_valid,
    input  wire logic [23:0] sinc2_data,
    output logic             data_ready_n,
    output logic             result_valid,
    input  wire logic        result_ready,
    output logic [23:0]      result_data,
    output logic             fir_rate_error
);
    // Link side: shift in command bits on the falling serial edge
    logic [4:0] bit_cnt_q;
    logic [7:0] cmd_sh_q;
    logic       start_tgl_q;
    logic       stop_tgl_q;

    // Command decoded on the 32nd falling edge of the frame
    always_ff @(negedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt_q   <= '0;
            cmd_sh_q    <= 8'h00;
            start_tgl_q <= 1'b0;
            stop_tgl_q  <= 1'b0;
        end
        else if (cs_n)
        begin
            bit_cnt_q <= '0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q < 5'h08)
            begin
                cmd_sh_q <= {cmd_sh_q[6:0], sdi};
            end
            if (bit_cnt_q == 5'(acc_pkg::CMD_BITS - 1))
            begin
                if (cmd_sh_q == acc_pkg::CMD_START)
                begin
                    start_tgl_q <= ~start_tgl_q;
                end
                if (cmd_sh_q == acc_pkg::CMD_STOP)
                begin
                    stop_tgl_q <= ~stop_tgl_q;
                end
            end
        end
    end

    // Three-stage synchronisers; a change counts when stages two and three agree
    logic [2:0] start_tgl_s_q;
    logic [2:0] stop_tgl_s_q;
    logic [2:0] pin_s_q;
    logic       start_tgl_seen_q;
    logic       stop_tgl_seen_q;
    logic       pin_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_tgl_s_q <= 3'h0;
            stop_tgl_s_q  <= 3'h0;
            pin_s_q       <= 3'h0;
        end
        else
        begin
            start_tgl_s_q <= {start_tgl_s_q[1:0], start_tgl_q};
            stop_tgl_s_q  <= {stop_tgl_s_q[1:0], stop_tgl_q};
            pin_s_q       <= {pin_s_q[1:0], start_pin};
        end
    end

    // Filtered levels, updated only when the last two stages agree
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_tgl_seen_q <= 1'b0;
            stop_tgl_seen_q  <= 1'b0;
            pin_q            <= 1'b0;
        end
        else
        begin
            if (start_tgl_s_q[1] == start_tgl_s_q[2])
            begin
                start_tgl_seen_q <= start_tgl_s_q[2];
            end
            if (stop_tgl_s_q[1] == stop_tgl_s_q[2])
            begin
                stop_tgl_seen_q <= stop_tgl_s_q[2];
            end
            if (pin_s_q[1] == pin_s_q[2])
            begin
                pin_q <= pin_s_q[2];
            end
        end
    end

    logic start_cmd_q;
    logic stop_cmd_q;
    logic pin_d1_q;

    // Event pulses from the filtered toggles and the pin's edges
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_cmd_q <= 1'b0;
            stop_cmd_q  <= 1'b0;
            pin_d1_q    <= 1'b0;
        end
        else
        begin
            start_cmd_q <= (start_tgl_s_q[2] == start_tgl_s_q[1]) && (start_tgl_s_q[2] != start_tgl_seen_q);
            stop_cmd_q  <= (stop_tgl_s_q[2] == stop_tgl_s_q[1]) && (stop_tgl_s_q[2] != stop_tgl_seen_q);
            pin_d1_q    <= pin_q;
        end
    end

    logic pin_rise;
    logic pin_fall;
    logic start_req;
    logic stop_req;
    logic pulse_mode;
    logic [4:0] rate_sel;
    logic [2:0] filt_sel;
    logic fir_sel;
    logic rate_ok;

    assign pin_rise   = pin_q && !pin_d1_q;
    assign pin_fall   = !pin_q && pin_d1_q;
    // Either source may start; the host keeps the pin low when using commands
    assign start_req  = pin_rise || start_cmd_q;
    assign stop_req   = pin_fall || stop_cmd_q;
    assign pulse_mode = mode_config_1[acc_pkg::MODE_BIT];
    assign rate_sel   = mode_config_0[acc_pkg::DR_LSB +: 5];
    assign filt_sel   = mode_config_0[acc_pkg::FILT_LSB +: 3];
    assign fir_sel    = (filt_sel == acc_pkg::FILT_FIR);

    // Averaging length, in 20 SPS words, for the four FIR rates
    function automatic logic [3:0] avg_len(input logic [4:0] dr);
        case (dr)
            acc_pkg::DR_2P5: avg_len = 4'h8;
            acc_pkg::DR_5:   avg_len = 4'h4;
            acc_pkg::DR_10:  avg_len = 4'h2;
            default:         avg_len = 4'h1;
        endcase
    endfunction

    // FIR only legal at the four slow rates
    assign rate_ok = (rate_sel == acc_pkg::DR_2P5) || (rate_sel == acc_pkg::DR_5) ||
                     (rate_sel == acc_pkg::DR_10) || (rate_sel == acc_pkg::DR_20);

    // Conversion sequencer
    acc_pkg::acc_state_t state_q;
    logic                stop_pend_q;
    logic                conv_done;
    logic                restart;

    // A restart clears the filter so the first result is settled
    assign restart = start_req;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q     <= acc_pkg::ACC_IDLE;
            stop_pend_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                acc_pkg::ACC_IDLE:
                begin
                    stop_pend_q <= 1'b0;
                    if (start_req)
                    begin
                        state_q <= acc_pkg::ACC_CONV;
                    end
                end
                acc_pkg::ACC_CONV:
                begin
                    if (restart)
                    begin
                        stop_pend_q <= 1'b0;
                    end
                    else if (stop_req && !pulse_mode)
                    begin
                        stop_pend_q <= 1'b1;
                    end
                    if (!restart && conv_done)
                    begin
                        if (pulse_mode || stop_pend_q || (stop_req && !pulse_mode))
                        begin
                            state_q <= acc_pkg::ACC_DONE;
                        end
                    end
                end
                acc_pkg::ACC_DONE:
                begin
                    stop_pend_q <= 1'b0;
                    state_q     <= start_req ? acc_pkg::ACC_CONV : acc_pkg::ACC_IDLE;
                end
                default:
                begin
                    state_q <= acc_pkg::ACC_IDLE;
                end
            endcase
        end
    end

    // Back-end filter: boxcar over FIR_DECIM inputs, then averaging stage
    logic [9:0]  dec_cnt_q;
    logic [33:0] fir_acc_q;
    logic [3:0]  avg_cnt_q;
    logic [26:0] avg_acc_q;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [23:0] fifo_in_data;
    logic        running;
    logic        fir_word;
    logic [23:0] fir_out;
    logic [33:0] fir_sum;
    logic [26:0] avg_sum;

    assign running  = (state_q == acc_pkg::ACC_CONV) && !restart;
    // Input stalls while the FIFO is full, so back-pressure reaches the filter
    assign fir_word = running && sinc2_valid && fifo_in_ready &&
                      (dec_cnt_q == acc_pkg::FIR_DECIM_M1);
    assign fir_sum  = fir_acc_q + 34'(signed'(sinc2_data));
    // Signed divide, so a negative input level averages to itself
    assign fir_out  = 24'(signed'(fir_sum) / signed'(34'(acc_pkg::FIR_DECIM)));
    assign avg_sum  = avg_acc_q + 27'(signed'(fir_out));
    assign conv_done = fir_word && (avg_cnt_q + 4'h1 >= avg_len(rate_sel));

    // First result after start uses only fresh inputs: one period, settled
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            dec_cnt_q <= '0;
            fir_acc_q <= '0;
            avg_cnt_q <= '0;
            avg_acc_q <= '0;
        end
        else if (!running)
        begin
            dec_cnt_q <= '0;
            fir_acc_q <= '0;
            avg_cnt_q <= '0;
            avg_acc_q <= '0;
        end
        else if (sinc2_valid && fifo_in_ready)
        begin
            if (fir_word)
            begin
                dec_cnt_q <= '0;
                fir_acc_q <= '0;
                avg_cnt_q <= conv_done ? 4'h0 : avg_cnt_q + 4'h1;
                avg_acc_q <= conv_done ? 27'h000_0000 : avg_sum;
            end
            else
            begin
                dec_cnt_q <= dec_cnt_q + 10'h001;
                fir_acc_q <= fir_acc_q + 34'(signed'(sinc2_data));
            end
        end
    end

    // Averaged word, divided by the power-of-two length
    function automatic logic [23:0] avg_out(input logic [26:0] s, input logic [3:0] n);
        case (n)
            4'h8:    avg_out = s[26:3];
            4'h4:    avg_out = s[25:2];
            4'h2:    avg_out = s[24:1];
            default: avg_out = s[23:0];
        endcase
    endfunction

    assign fifo_in_valid = conv_done;
    assign fifo_in_data  = avg_out(avg_sum, avg_len(rate_sel));

    logic        fifo_out_valid;
    logic [23:0] fifo_out_data;

    acc_fifo #(
        .WIDTH (acc_pkg::DATA_W),
        .DEPTH (acc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst_n     (rstn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (!result_valid),
        .out_data  (fifo_out_data)
    );

    // Ready indicator: high at start, low once a result is held
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_ready_n <= 1'b1;
        end
        else if (start_req)
        begin
            data_ready_n <= 1'b1;
        end
        else if (conv_done)
        begin
            data_ready_n <= 1'b0;
        end
    end

    // Output register; result readable one cycle after data_ready_n falls, once the register is free
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_valid <= 1'b0;
            result_data  <= 24'h00_0000;
        end
        else if (result_valid)
        begin
            if (result_ready)
            begin
                result_valid <= 1'b0;
            end
        end
        else if (fifo_out_valid)
        begin
            result_valid <= 1'b1;
            result_data  <= fifo_out_data;
        end
    end

    // Flag an FIR choice at an unsupported rate
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fir_rate_error <= 1'b0;
        end
        else
        begin
            fir_rate_error <= fir_sel && !rate_ok;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/acc_pkg.sv ----
// Behaviour
// - Start pin or serial command governs conversions
// - Serial command acts at 32nd falling edge
// - Mode bit four picks continuous or pulse
// - Continuous mode converts back to back until stopped
// - Pulse mode converts once then halts
// - Ready goes high at start, low when done
// - Stop lets running conversion finish first
// - Pin re-rise or new start restarts conversion
// - FIR allowed only at 2.5/5/10/20 SPS
// - FIR first result settled in one period
// - FIR takes second sinc output, gives 20 SPS
// - Averaging after FIR gives 10/5/2.5 SPS
// - First sinc stage nulls at rate multiples
// - Second sinc fed 14.4 kHz, five nulls at 2.4k
// - Higher sinc order deepens 50/60 Hz rejection
// - Pulse mode stop never interrupts conversion
// - Rate and filter fields in mode config zero
`default_nettype none
package acc_pkg;
    localparam int unsigned DATA_W       = 24;
    localparam int unsigned FIFO_DEPTH   = 8;
    localparam int unsigned CMD_BITS     = 32;
    localparam int unsigned MODE_BIT     = 4;
    localparam logic [7:0]  MODE_CONFIG_1_RESET  = 8'h00;
    localparam logic [7:0]  MODE_CONFIG_0_RESET  = 8'h24;
    localparam int unsigned DR_LSB       = 3;
    localparam int unsigned FILT_LSB     = 0;
    localparam logic [2:0]  FILT_FIR     = 3'h4;
    localparam logic [4:0]  DR_2P5       = 5'h00;
    localparam logic [4:0]  DR_5         = 5'h01;
    localparam logic [4:0]  DR_10        = 5'h02;
    localparam logic [4:0]  DR_20        = 5'h04;
    localparam logic [7:0]  CMD_START    = 8'h08;
    localparam logic [7:0]  CMD_STOP     = 8'h0a;
    // Second-stage input words per 20 SPS FIR output (14.4 kHz / 20)
    localparam int unsigned SINC2_IN_KHZX10 = 144;
    localparam int unsigned FIR_DECIM    = SINC2_IN_KHZX10 * 100 / 20;
    localparam logic [9:0]  FIR_DECIM_M1 = 10'(FIR_DECIM - 1);
    typedef enum logic [2:0]
    {
        ACC_IDLE = 3'h1,
        ACC_CONV = 3'h2,
        ACC_DONE = 3'h4
    } acc_state_t;
endpackage
`default_nettype wire

// ---- hdl/acc_fifo.sv ----
`default_nettype none
module acc_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- test/acc_conv_ctrl_chk.sv ----
`default_nettype none
module acc_conv_ctrl_chk (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        sclk,
    input wire logic        sdi,
    input wire logic        cs_n,
    input wire logic        start_pin,
    input wire logic [7:0]  mode_config_0,
    input wire logic [7:0]  mode_config_1,
    input wire logic        sinc2_valid,
    input wire logic [23:0] sinc2_data,
    input wire logic        data_ready_n,
    input wire logic        result_valid,
    input wire logic        result_ready,
    input wire logic [23:0] result_data,
    input wire logic        fir_rate_error
);
    logic [5:0]  evt_q;
    logic [5:0]  gap_q;
    logic [11:0] words_q;
    logic [4:0]  dr;
    logic        fir_bad;
    // FIR is legal only at the four slow rates
    assign dr = mode_config_0[7:3];
    assign fir_bad = mode_config_0[2:0] == acc_pkg::FILT_FIR && dr != acc_pkg::DR_2P5
                     && dr != acc_pkg::DR_5 && dr != acc_pkg::DR_10 && dr != acc_pkg::DR_20;
    // Cycles since host activity; saturates so a long idle never wraps
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            evt_q <= '0;
        else if (!cs_n || $rose(start_pin))
            evt_q <= '0;
        else if (evt_q != 6'h3f)
            evt_q <= evt_q + 6'h01;
    end
    // Cycles since the last input word
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            gap_q <= '0;
        else if (sinc2_valid)
            gap_q <= '0;
        else if (gap_q != 6'h3f)
            gap_q <= gap_q + 6'h01;
    end
    // Words since a conversion began; restarts can make it count high, and a word one cycle after data_ready_n rises is not counted
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            words_q <= '0;
        else if ($rose(data_ready_n) || $rose(start_pin))
            words_q <= '0;
        else if (sinc2_valid && words_q != 12'hfff)
            words_q <= words_q + 12'h001;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    AST_RESET_QUIET: assert property ($rose(rstn) |-> data_ready_n && !result_valid)
        else $error("outputs busy after reset");
    AST_RESULT_HOLD: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("result lost while stalled");
    AST_VALID_AT_READY: assert property ($rose(result_valid) |-> !data_ready_n)
        else $error("result before ready low");
    AST_VALID_FOLLOWS: assert property ($fell(data_ready_n) |-> ##[0:8] result_valid)
        else $error("no result after ready low");
    AST_FIR_RATE_FLAG: assert property ($stable(mode_config_0) [*3] |-> fir_rate_error == fir_bad)
        else $error("rate error flag wrong");
    AST_DONE_NEEDS_WORD: assert property ($fell(data_ready_n) |-> gap_q < 6'h14)
        else $error("done without input");
    AST_DECIM_COUNT: assert property ($fell(data_ready_n) |-> words_q >= 12'(acc_pkg::FIR_DECIM - 16))
        else $error("done too early");
    AST_PULSE_NO_SELF_START: assert property (mode_config_1[4] && $rose(data_ready_n) |-> evt_q < 6'h28)
        else $error("pulse mode started alone");
    COV_DONE: cover property ($fell(data_ready_n));
    COV_STALL: cover property (result_valid && !result_ready ##1 result_valid);
    COV_RATE_ERR: cover property ($rose(fir_rate_error));
endmodule
bind acc_conv_ctrl acc_conv_ctrl_chk u_chk (
    .mclk(mclk), .rstn(rstn), .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .start_pin(start_pin),
    .mode_config_0(mode_config_0), .mode_config_1(mode_config_1), .sinc2_valid(sinc2_valid),
    .sinc2_data(sinc2_data), .data_ready_n(data_ready_n), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data), .fir_rate_error(fir_rate_error)
);
`default_nettype wire

// ---- test/acc_host_model.sv ----
`default_nettype none
module acc_host_model (
    output logic sclk,
    output logic sdi,
    output logic cs_n,
    output logic start_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: frame closed, link clock parked low
    initial
    begin
        sclk = 1'b0;
        sdi = 1'b1;
        cs_n = 1'b1;
        start_pin = 1'b0;
    end
    // Opcode leads a 32-bit frame; odd offset keeps it out of phase with mclk
    task automatic send_cmd(input logic [7:0] op);
        logic [31:0] w;
        w = {op, 24'h00_0000};
        #5.3 cs_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            #16 sdi = w[i];
            sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit
    endtask
    task automatic pin(input logic lvl);
        start_pin = lvl;
    endtask
endmodule
`default_nettype wire

// ---- test/acc_conv_ctrl_test.sv ----
`default_nettype none
module acc_conv_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk;
    logic        rstn;
    wire logic   sclk;
    wire logic   sdi;
    wire logic   cs_n;
    wire logic   start_pin;
    logic [7:0]  mode_config_0;
    logic [7:0]  mode_config_1;
    logic        sinc2_valid;
    logic [23:0] sinc2_data;
    logic        data_ready_n;
    logic        result_valid;
    logic        result_ready;
    logic [23:0] result_data;
    logic        fir_rate_error;
    logic [23:0] last_res;
    int          n_res;
    int          n_fail;
    int          total_checks;
    acc_host_model host (.sclk(sclk), .sdi(sdi), .cs_n(cs_n), .start_pin(start_pin));
    acc_conv_ctrl uut (
        .mclk(mclk), .rstn(rstn), .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .start_pin(start_pin),
        .mode_config_0(mode_config_0), .mode_config_1(mode_config_1), .sinc2_valid(sinc2_valid),
        .sinc2_data(sinc2_data), .data_ready_n(data_ready_n), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data), .fir_rate_error(fir_rate_error)
    );
    // 250 MHz system clock
    always #2 mclk = ~mclk;
    // Log every accepted result; scenarios judge them
    always @(posedge mclk)
    begin
        if (result_valid === 1'b1 && result_ready === 1'b1)
        begin
            n_res++;
            last_res = result_data;
        end
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One word every other cycle, so the FIFO never refuses
    task automatic feed(input int n, input logic [23:0] v);
        for (int i = 0; i < n; i++)
        begin
            sinc2_data = v + ((i % 2 == 0) ? 24'h00_0010 : 24'hFF_FFF0); // Even runs average back to v
            sinc2_valid = 1'b1;
            cyc(1);
            sinc2_valid = 1'b0;
            cyc(1);
        end
    endtask
    task automatic wait_data_ready_n(input logic lvl);
        int k;
        k = 0;
        while (data_ready_n !== lvl && k < 300)
        begin
            cyc(1);
            k++;
        end
        check("data_ready_n", 24'(data_ready_n), 24'(lvl));
    endtask
    task automatic t_fir_err();
        for (int r = 0; r < 32; r++)
        begin
            mode_config_0 = {5'(r), acc_pkg::FILT_FIR};
            cyc(4);
            check("rate_err", 24'(fir_rate_error), 24'(r > 2 && r != 4));
        end
        mode_config_0 = {5'h03, 3'h0};
        cyc(4);
        check("rate_err sinc", 24'(fir_rate_error), 24'h00_0000);
    endtask
    task automatic t_pulse_rates();
        logic [4:0]  dr [4] = '{acc_pkg::DR_20, acc_pkg::DR_10, acc_pkg::DR_5, acc_pkg::DR_2P5};
        logic [23:0] v;
        int          n;
        mode_config_1 = 8'h10;
        for (int i = 0; i < 4; i++)
        begin
            mode_config_0 = {dr[i], acc_pkg::FILT_FIR};
            v = 24'h0A_5000 - 24'(i) * 24'h05_0000;
            result_ready = 1'b0;
            n = n_res;
            host.pin(1'b1);
            cyc(8); // Let the pin pass its synchroniser before words flow
            wait_data_ready_n(1'b1);
            feed(acc_pkg::FIR_DECIM * (1 << i), v);
            wait_data_ready_n(1'b0);
            cyc(12);
            check("held valid", 24'(result_valid), 24'h00_0001);
            result_ready = 1'b1;
            cyc(40);
            check("result", last_res, v);
            check("count", 24'(n_res - n), 24'h00_0001);
            check("halted", 24'(data_ready_n), 24'h00_0000);
            host.pin(1'b0);
            cyc(6);
        end
    endtask
    task automatic t_restart();
        int n;
        n = n_res;
        mode_config_0 = {acc_pkg::DR_20, acc_pkg::FILT_FIR};
        host.pin(1'b1);
        wait_data_ready_n(1'b1);
        feed(400, 24'h7F_0000);
        host.pin(1'b0);
        cyc(6);
        host.pin(1'b1);
        cyc(10);
        feed(200, 24'h00_0777);
        host.pin(1'b0);
        feed(520, 24'h00_0777);
        wait_data_ready_n(1'b0);
        cyc(12);
        check("restart result", last_res, 24'h00_0777);
        check("restart count", 24'(n_res - n), 24'h00_0001);
    endtask
    task automatic t_cont();
        int n;
        mode_config_1 = 8'h00;
        mode_config_0 = {acc_pkg::DR_20, acc_pkg::FILT_FIR};
        n = n_res;
        host.pin(1'b0);
        host.send_cmd(acc_pkg::CMD_START);
        wait_data_ready_n(1'b1);
        feed(720, 24'h00_1000);
        cyc(12);
        check("first", last_res, 24'h00_1000);
        feed(720, 24'h00_2000);
        cyc(12);
        check("second", last_res, 24'h00_2000);
        feed(360, 24'h00_3000);
        host.send_cmd(acc_pkg::CMD_STOP);
        cyc(1);
        feed(360, 24'h00_3000);
        cyc(12);
        check("after stop", last_res, 24'h00_3000);
        feed(720, 24'h00_4000);
        cyc(12);
        check("cont count", 24'(n_res - n), 24'h00_0003);
    endtask
    task automatic t_idle_stop();
        int n;
        n = n_res;
        host.send_cmd(acc_pkg::CMD_STOP);
        cyc(20);
        check("idle ready", 24'(data_ready_n), 24'h00_0000);
        check("idle count", 24'(n_res - n), 24'h00_0000);
    endtask
    // Main sequence
    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        n_res = 0;
        n_fail = 0;
        total_checks = 0;
        sinc2_valid = 1'b0;
        sinc2_data = 24'h00_0000;
        result_ready = 1'b1;
        mode_config_0 = acc_pkg::MODE_CONFIG_0_RESET;
        mode_config_1 = acc_pkg::MODE_CONFIG_1_RESET;
        cyc(10);
        rstn = 1'b1;
        cyc(2);
        t_fir_err();
        t_pulse_rates();
        t_restart();
        t_cont();
        t_idle_stop();
        test_done();
    end
    // Watchdog: about three times the expected run
    initial
    begin
        #400_000;
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
